// ---- verilog/frd_read_cmd.sv ----
// Purpose: command phases and sector read engine of a floppy controller
// Assumes: id fields, data marks and bytes arrive decoded on clk_sys
// Notes: write and verify search like a read but deliver no bytes
`timescale 1ns/1ns
`include "frd_map.svh"
module frd_read_cmd import frd_pkg::*; #(
  parameter int MS_CYCLES = `FRD_MS_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // command and result bytes
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  input wire logic res_rd,
  output logic [7:0] res_data,
  output logic res_valid,
  // sector data stream and terminal count pin
  output logic [7:0] xfer_data,
  output logic xfer_valid,
  input wire logic xfer_ready,
  input wire logic terminal_count,
  // configuration from setup commands
  input wire logic implied_seek_en,
  input wire logic [7:0] settle_ms,
  input wire logic [7:0] unload_ms,
  // seek engine
  output logic seek_req,
  output logic [7:0] seek_cyl,
  input wire logic seek_done,
  input wire logic seek_fail,
  input wire logic [7:0] seek_fail_cyl,
  // drive and data separator
  input wire logic index_pulse_in_b,
  input wire logic id_valid,
  input wire logic [7:0] id_cyl,
  input wire logic [7:0] id_head,
  input wire logic [7:0] id_sec,
  input wire logic [7:0] id_size,
  input wire logic id_crc_ok,
  input wire logic mark_valid,
  input wire logic mark_deleted,
  input wire logic disk_byte_valid,
  input wire logic [7:0] disk_byte,
  input wire logic data_crc_done,
  input wire logic data_crc_ok,
  output logic head_load,
  output logic drive_busy,
  // perpendicular, lock and dump state
  output logic overwrite_enable,
  output logic [3:0] perp_drive_bits,
  output logic gap_length_select,
  output logic write_gate_timing,
  output logic lock_state,
  output logic [7:0] dump_sc_eot
);
  frd_reg_t q;
  frd_reg_t n;
  logic buf_in_ready;
  logic tick;
  logic ix_rise;
  logic go_res;
  logic read_op;
  logic del_cmd;
  logic multi_track;
  logic skip_deleted;
  logic id_match;
  logic last_sector;
  logic [14:0] sect_bytes;
  logic [14:0] xfer_len;

  frd_pair_buf u_buf (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_valid(q.push),
    .in_data(q.push_data),
    .in_ready(buf_in_ready),
    .out_valid(xfer_valid),
    .out_data(xfer_data),
    .out_ready(xfer_ready)
  );

  assign cmd_ready = (q.st == S_IDLE) || (q.st == S_PARAM); // R23
  assign res_valid = (q.st == S_RESULT); // R23
  assign res_data = q.res[q.ridx];
  assign seek_req = (q.st == S_SEEK);
  assign seek_cyl = q.prm[2];
  assign head_load = q.head_ld;
  assign drive_busy = (q.st == S_SEEK) || (q.st == S_SETTLE) ||
                      (q.st == S_SEARCH) || (q.st == S_DATA); // R5
  assign overwrite_enable = q.perp[7];
  assign perp_drive_bits = q.perp[5:2];
  assign gap_length_select = q.perp[1];
  assign write_gate_timing = q.perp[0];
  assign lock_state = q.lock;
  assign dump_sc_eot = q.fmt_last ? q.fmt_sc : q.eot_last; // R20

  always_comb begin
    n = q;
    go_res = 1'b0;
    last_sector = 1'b0;
    tick = (q.ms_cnt == 14'(MS_CYCLES - 1));
    n.ms_cnt = tick ? 14'd0 : q.ms_cnt + 14'd1;
    n.push = 1'b0;
    // pin inputs: a change counts once second and third stage agree
    n.tc_s = {q.tc_s[1:0], terminal_count};
    n.ix_s = {q.ix_s[1:0], ~index_pulse_in_b};
    if (q.tc_s[2] == q.tc_s[1]) n.tc_l = q.tc_s[2];
    if (q.ix_s[2] == q.ix_s[1]) n.ix_l = q.ix_s[2];
    ix_rise = n.ix_l && !q.ix_l;
    // bits 0-4 pick the operation, all else shared
    read_op = (q.prm[0][4:0] == `FRD_OP_RD) || (q.prm[0][4:0] == `FRD_OP_RDDEL); // R4
    del_cmd = (q.prm[0][4:0] == `FRD_OP_RDDEL);
    multi_track = q.prm[0][7];
    skip_deleted = q.prm[0][5];
    sect_bytes = `FRD_SECT_BASE << q.prm[5][2:0]; // R11
    if (q.prm[5][2:0] == 3'd0 && q.prm[8] < `FRD_DTL_LIMIT) begin
      xfer_len = {7'd0, q.prm[8]}; // R12
    end else begin
      xfer_len = sect_bytes; // R13
    end
    id_match = (id_cyl == q.cyl) && (id_head == q.hd) &&
               (id_sec == q.sec) && (id_size == q.prm[5]); // R8
    // overrun acts as an implied terminal count
    if (q.push && !buf_in_ready) n.stop = 1'b1; // R10
    unique case (q.st)
      S_IDLE: begin
        if (q.head_ld && tick) begin
          if (q.tmr == 8'd0) begin
            n.head_ld = 1'b0; // R15
          end else begin
            n.tmr = q.tmr - 8'd1;
          end
        end
        if (cmd_wr) begin
          n.prm[0] = cmd_data;
          n.cls = frd_cmd_class(cmd_data);
          n.plen = frd_cmd_len(n.cls);
          n.pcnt = 4'd1;
          n.ridx = 3'd0;
          n.rlen = 3'd1;
          if (n.cls == CL_BAD) begin
            n.res[0] = `FRD_RES_INVALID; // R1
            n.st = S_RESULT; // R1
          end else if (n.cls == CL_LOCK) begin
            n.lock = cmd_data[7];
            n.res[0] = {3'd0, cmd_data[7], 4'd0};
            n.st = S_RESULT;
          end else begin
            n.st = S_PARAM;
          end
        end
      end
      S_PARAM: begin
        if (cmd_wr) begin
          n.prm[q.pcnt] = cmd_data;
          n.pcnt = q.pcnt + 4'd1;
          if (q.pcnt == q.plen - 4'd1) begin // R7
            unique case (q.cls)
              CL_PERP: begin
                n.perp = cmd_data; // R2
                n.st = S_IDLE;
              end
              CL_FMT: begin
                n.fmt_last = 1'b1; // R20
                n.fmt_sc = q.prm[3];
                n.st0 = 8'd0;
                n.st1 = 8'd0;
                n.st2 = 8'd0;
                go_res = 1'b1;
              end
              default: begin
                if (q.cls == CL_DATA) begin
                  n.fmt_last = 1'b0; // R20
                  n.eot_last = q.prm[6];
                end
                n.cyl = q.prm[2];
                n.hd = q.prm[3];
                n.sec = q.prm[4];
                n.st0 = 8'd0;
                n.st1 = 8'd0;
                n.st2 = 8'd0;
                n.stop = 1'b0;
                n.matched = 1'b0;
                n.idx_seen = 1'b0;
                n.tmr = q.head_ld ? 8'd0 : settle_ms; // R15
                n.st = implied_seek_en ? S_SEEK : S_SETTLE; // R5
              end
            endcase
          end
        end
      end
      S_SEEK: begin
        if (seek_fail) begin
          n.st0 = `FRD_ST0_ABN | `FRD_ST0_EQUIP; // R6
          n.cyl = seek_fail_cyl; // R6
          go_res = 1'b1;
        end else if (seek_done) begin
          n.st = S_SETTLE;
        end
      end
      S_SETTLE: begin
        n.head_ld = 1'b1; // R8
        if (q.tmr == 8'd0) begin
          n.st = S_SEARCH;
        end else if (tick) begin
          n.tmr = q.tmr - 8'd1;
        end
      end
      S_SEARCH: begin
        if (q.stop) begin
          go_res = 1'b1; // R10
        end else if (ix_rise && q.idx_seen) begin
          n.st0 = q.st0 | `FRD_ST0_ABN; // R16
          n.st1 = q.st1 | `FRD_ST1_NO_DATA; // R16
          go_res = 1'b1;
        end else if (ix_rise) begin
          n.idx_seen = 1'b1;
        end else if (id_valid && !id_crc_ok && q.cls != CL_RDID) begin
          n.st0 = q.st0 | `FRD_ST0_ABN; // R17
          n.st1 = q.st1 | `FRD_ST1_DATA_ERR; // R17
          n.st2 = q.st2 | `FRD_ST2_DATA_CRC; // R17
          go_res = 1'b1;
        end else if (id_valid && id_crc_ok && q.cls == CL_RDID) begin
          n.cyl = id_cyl; // R3
          n.hd = id_head;
          n.sec = id_sec;
          n.prm[5] = id_size;
          go_res = 1'b1;
        end else if (id_valid) begin
          n.matched = id_crc_ok && id_match; // R8
        end else if (mark_valid && q.matched) begin
          n.matched = 1'b0;
          n.deleted = mark_deleted ^ del_cmd;
          n.pos = 15'd0;
          n.st = S_DATA;
        end
      end
      S_DATA: begin
        if (disk_byte_valid) begin
          n.pos = q.pos + 15'd1;
          // skipped sector and stopped transfer still run to the crc
          if (read_op && !(q.deleted && skip_deleted) && !q.stop && q.pos < xfer_len) begin
            n.push = 1'b1; // R8
            n.push_data = disk_byte;
          end
        end
        if (data_crc_done) begin
          if (!data_crc_ok) begin
            n.st0 = q.st0 | `FRD_ST0_ABN; // R17
            n.st1 = q.st1 | `FRD_ST1_DATA_ERR; // R17
            go_res = 1'b1;
          end else if (q.deleted && !skip_deleted) begin
            n.st2 = q.st2 | `FRD_ST2_CTRL_MARK; // R18
            go_res = 1'b1; // R18
          end else begin
            if (q.deleted) n.st2 = q.st2 | `FRD_ST2_CTRL_MARK; // R19
            if (q.sec == q.prm[6]) begin
              n.sec = 8'd1;
              n.hd = {q.hd[7:1], ~q.hd[0]};
              if (multi_track && !q.hd[0]) begin
                last_sector = 1'b0; // R14
              end else begin
                if (!multi_track) n.hd = q.hd;
                n.cyl = q.cyl + 8'd1;
                last_sector = 1'b1;
              end
            end else begin
              n.sec = q.sec + 8'd1; // R9
            end
            if (last_sector || q.stop || n.stop || n.tc_l) begin
              go_res = 1'b1; // R10
            end else begin
              n.idx_seen = 1'b0;
              n.st = S_SEARCH; // R9
            end
          end
        end
      end
      S_RESULT: begin
        if (res_rd) begin
          n.ridx = q.ridx + 3'd1;
          if (q.ridx == q.rlen - 3'd1) begin
            n.st = S_IDLE;
            n.tmr = unload_ms; // R15
          end
        end
      end
      default: begin
        n.st = S_IDLE;
      end
    endcase
    if (n.tc_l && (q.st == S_SEARCH || q.st == S_DATA)) n.stop = 1'b1; // R10
    if (go_res) begin
      // drive select bits only echo into status 0
      n.res[0] = n.st0 | {5'd0, q.prm[1][2:0]}; // R21
      n.res[1] = n.st1; // R22
      n.res[2] = n.st2;
      n.res[3] = n.cyl;
      n.res[4] = n.hd;
      n.res[5] = n.sec;
      n.res[6] = n.prm[5];
      n.rlen = `FRD_RES_LEN; // R22
      n.ridx = 3'd0;
      n.st = S_RESULT;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  property p_invalid_result;
    @(posedge clk_sys) disable iff (!rst_b)
      (q.st == S_IDLE && cmd_wr && frd_cmd_class(cmd_data) == CL_BAD)
      |=> (res_valid && res_data == `FRD_RES_INVALID && q.rlen == 3'd1);
  endproperty
  a_invalid_result: assert property (p_invalid_result) else $error("bad code result"); // R1

  property p_perp_load;
    @(posedge clk_sys) disable iff (!rst_b)
      (q.st == S_PARAM && q.cls == CL_PERP && cmd_wr)
      |=> (q.perp == $past(cmd_data) && q.st == S_IDLE);
  endproperty
  a_perp_load: assert property (p_perp_load) else $error("perp byte not taken"); // R2

  property p_seek_busy;
    @(posedge clk_sys) disable iff (!rst_b) seek_req |-> drive_busy;
  endproperty
  a_seek_busy: assert property (p_seek_busy) else $error("busy low during seek"); // R5

  property p_seek_fail;
    @(posedge clk_sys) disable iff (!rst_b)
      (q.st == S_SEEK && seek_fail)
      |=> (res_valid && q.res[3] == $past(seek_fail_cyl) && q.res[0][7:6] == 2'b01);
  endproperty
  a_seek_fail: assert property (p_seek_fail) else $error("seek failure report"); // R6

  property p_search_loaded;
    @(posedge clk_sys) disable iff (!rst_b)
      (q.st == S_SEARCH || q.st == S_DATA) |-> head_load;
  endproperty
  a_search_loaded: assert property (p_search_loaded) else $error("search unloaded"); // R8

  property p_stop_quiet;
    @(posedge clk_sys) disable iff (!rst_b) (q.stop && $past(q.stop)) |=> !q.push;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("byte after stop"); // R10

  property p_no_data;
    @(posedge clk_sys) disable iff (!rst_b)
      (q.st == S_SEARCH && !q.stop && q.idx_seen && ix_rise)
      |=> (res_valid && q.res[1][2] && q.res[0][7:6] == 2'b01);
  endproperty
  a_no_data: assert property (p_no_data) else $error("no-data not reported"); // R16

  property p_seven_bytes;
    @(posedge clk_sys) disable iff (!rst_b)
      (q.st == S_DATA && data_crc_done && !data_crc_ok)
      |=> (q.rlen == 3'd7 && q.ridx == 3'd0 && q.res[1][5]);
  endproperty
  a_seven_bytes: assert property (p_seven_bytes) else $error("result length"); // R22

  property p_ports_excl;
    @(posedge clk_sys) disable iff (!rst_b) !(cmd_ready && res_valid);
  endproperty
  a_ports_excl: assert property (p_ports_excl) else $error("ready and valid both"); // R23

endmodule : frd_read_cmd

// ---- inc/frd_map.svh ----
// Purpose: constants for the floppy data-transfer command block
// Assumes: one 10 MHz system clock, byte-wide command and result port
// Notes: Behaviour list below, one tag per line
//
// Behaviour
// [R1] unknown command byte is a no-op to standby, result is one byte 80h
// [R2] perpendicular setup code 12h, then one byte of ow, drive, gap, gate bits
// [R3] read-id returns first error-free id on the cylinder in the result bytes
// [R4] read, write, verify share parameters and results; only bits 0-4 differ
// [R5] implied seek runs first when enabled, drive busy active during it
// [R6] failed implied seek reports error in status 0 and failing cylinder
// [R7] host writes nine bytes to start a sector read
// [R8] load head if unloaded, settle, scan ids, stream matching sector into fifo
// [R9] after each sector, increment sector number and read the next one
// [R10] terminal count or overrun stops delivery, sector finishes with crc check
// [R11] size code n gives 128 shifted left by n bytes per sector, up to 07
// [R12] size zero and length byte below 128 transfers only that many bytes
// [R13] host sets length byte to ff for nonzero size; it is then ignored
// [R14] multi-track runs side 0 sector 1 through last sector of side 1
// [R15] head stays loaded until unload interval ends; early command skips settle
// [R16] two index pulses without the sector: code 01, no-data flag, end
// [R17] crc error: code 01, data-error flag, data-crc flag on bad id crc
// [R18] skip clear: deleted mark read, control-mark set, no increment, end
// [R19] skip set: deleted sector skipped unread, control-mark set
// [R20] dump byte gives sector count after format, end-of-track after read/write
// [R21] drive select bits are internal only; software keeps select pins matching
// [R22] data command result is seven bytes: st0, st1, st2, c, h, r, n
// [R23] host writes only when ready for input, reads only when output ready
`ifndef FRD_MAP_SVH
`define FRD_MAP_SVH

`define FRD_OP_RD 5'h06
`define FRD_OP_RDDEL 5'h0c
`define FRD_OP_WR 5'h05
`define FRD_OP_WRDEL 5'h09
`define FRD_OP_VFY 5'h16
`define FRD_OP_RDID 5'h0a
`define FRD_OP_FMT 5'h0d
`define FRD_OP_PERP 8'h12
`define FRD_OP_LOCK 7'h14
`define FRD_LEN_DATA 4'h9
`define FRD_LEN_TWO 4'h2
`define FRD_LEN_FMT 4'h6
`define FRD_LEN_ONE 4'h1
`define FRD_RES_INVALID 8'h80
`define FRD_RES_LEN 3'h7
`define FRD_ST0_ABN 8'h40
`define FRD_ST0_EQUIP 8'h10
`define FRD_ST1_DATA_ERR 8'h20
`define FRD_ST1_NO_DATA 8'h04
`define FRD_ST2_CTRL_MARK 8'h40
`define FRD_ST2_DATA_CRC 8'h20
`define FRD_SECT_BASE 15'h0080
`define FRD_DTL_LIMIT 8'h80
`define FRD_CLK_NS 100
`define FRD_T_MS_NS 1000000
`define FRD_MS_CYCLES (`FRD_T_MS_NS / `FRD_CLK_NS)

`endif

// ---- inc/frd_pkg.sv ----
// Purpose: types for the floppy data-transfer command block
// Assumes: frd_map.svh is on the include path
// Notes: state of each module is one packed struct
`include "frd_map.svh"
package frd_pkg;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_PARAM = 3'b001,
    S_SEEK = 3'b010,
    S_SETTLE = 3'b011,
    S_SEARCH = 3'b100,
    S_DATA = 3'b101,
    S_RESULT = 3'b110
  } frd_state_t;

  typedef enum logic [2:0] {
    CL_DATA = 3'b000,
    CL_RDID = 3'b001,
    CL_PERP = 3'b010,
    CL_LOCK = 3'b011,
    CL_FMT = 3'b100,
    CL_BAD = 3'b101
  } frd_class_t;

  typedef struct packed {
    frd_state_t st;
    frd_class_t cls;
    logic [8:0][7:0] prm;
    logic [3:0] pcnt;
    logic [3:0] plen;
    logic [6:0][7:0] res;
    logic [2:0] ridx;
    logic [2:0] rlen;
    logic [2:0] tc_s;
    logic [2:0] ix_s;
    logic tc_l;
    logic ix_l;
    logic stop;
    logic matched;
    logic deleted;
    logic idx_seen;
    logic [13:0] ms_cnt;
    logic [7:0] tmr;
    logic head_ld;
    logic [7:0] cyl;
    logic [7:0] hd;
    logic [7:0] sec;
    logic [14:0] pos;
    logic [7:0] st0;
    logic [7:0] st1;
    logic [7:0] st2;
    logic fmt_last;
    logic [7:0] fmt_sc;
    logic [7:0] eot_last;
    logic lock;
    logic [7:0] perp;
    logic push;
    logic [7:0] push_data;
  } frd_reg_t;

  typedef struct packed {
    logic [1:0][7:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } frd_buf_t;

  function automatic frd_class_t frd_cmd_class(input logic [7:0] b);
    if (b == `FRD_OP_PERP) return CL_PERP;
    if (b[6:0] == `FRD_OP_LOCK) return CL_LOCK;
    unique case (b[4:0])
      `FRD_OP_RD, `FRD_OP_RDDEL, `FRD_OP_WR, `FRD_OP_WRDEL, `FRD_OP_VFY: return CL_DATA;
      `FRD_OP_RDID: return CL_RDID;
      `FRD_OP_FMT: return CL_FMT;
      default: return CL_BAD;
    endcase
  endfunction : frd_cmd_class

  function automatic logic [3:0] frd_cmd_len(input frd_class_t c);
    unique case (c)
      CL_DATA: return `FRD_LEN_DATA;
      CL_RDID, CL_PERP: return `FRD_LEN_TWO;
      CL_FMT: return `FRD_LEN_FMT;
      default: return `FRD_LEN_ONE;
    endcase
  endfunction : frd_cmd_len

endpackage : frd_pkg

// ---- verilog/frd_pair_buf.sv ----
// Purpose: two-entry byte buffer between sector reader and transfer port
// Assumes: single clock, valid/ready on both sides
// Notes: in_ready low only when both entries hold data
`timescale 1ns/1ns
module frd_pair_buf import frd_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready
);
  frd_buf_t q;
  frd_buf_t n;
  logic do_in;
  logic do_out;

  assign in_ready = (q.cnt != 2'd2);
  assign out_valid = (q.cnt != 2'd0);
  assign out_data = q.mem[q.rp];

  always_comb begin
    n = q;
    do_in = in_valid && in_ready;
    do_out = out_valid && out_ready;
    if (do_in) begin
      n.mem[q.wp] = in_data;
      n.wp = ~q.wp;
    end
    if (do_out) begin
      n.rp = ~q.rp;
    end
    n.cnt = q.cnt + {1'b0, do_in} - {1'b0, do_out};
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  property p_no_overfill;
    @(posedge clk_sys) disable iff (!rst_b) (q.cnt == 2'd2 && !out_ready) |=> (q.cnt == 2'd2);
  endproperty
  a_no_overfill: assert property (p_no_overfill) else $error("buffer lost its fill"); // R10

endmodule : frd_pair_buf

// ---- dv/frd_drive_model.sv ----
// Purpose: spinning drive and data separator for the read engine
// Assumes: two 128-byte sectors per track, numbered 1 and 2
// Notes: starts a revolution only while the engine is busy, then finishes it; released lines invert
`timescale 1ns/1ns
module frd_drive_model (
  // clock and spin request
  input wire logic clk_sys,
  input wire logic spin,
  // decoded track stream
  output logic index_pulse_in_b,
  output logic id_valid,
  output logic [7:0] id_sec,
  output logic mark_valid,
  output logic mark_deleted,
  output logic disk_byte_valid,
  output logic [7:0] disk_byte,
  output logic data_crc_done,
  output logic data_crc_ok
);
  logic [1:0] del_mask = 2'h0;
  logic crc_bad = 1'b0;
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick
  // one revolution: index, then both sectors
  task automatic rev;
    index_pulse_in_b = 1'b0;
    repeat (3) tick();
    index_pulse_in_b = 1'b1;
    for (int s = 1; s <= 2; s++) begin
      repeat (4) tick();
      id_sec = 8'(s);
      id_valid = 1'b1;
      tick();
      id_valid = 1'b0;
      id_sec = ~id_sec;
      mark_deleted = del_mask[s-1];
      mark_valid = 1'b1;
      tick();
      mark_valid = 1'b0;
      tick();
      for (int i = 0; i < 128; i++) begin
        disk_byte = 8'(i);
        disk_byte_valid = 1'b1;
        tick();
        disk_byte_valid = 1'b0;
        disk_byte = ~disk_byte;
        tick();
      end
      data_crc_ok = !crc_bad;
      data_crc_done = 1'b1;
      tick();
      data_crc_done = 1'b0;
      data_crc_ok = crc_bad;
    end
  endtask : rev
  initial begin
    {index_pulse_in_b, id_valid, mark_valid, mark_deleted} = 4'h8;
    {disk_byte_valid, data_crc_done, data_crc_ok} = 3'h0;
    {id_sec, disk_byte} = 16'h0000;
    forever begin
      tick();
      if (spin) begin
        rev();
      end
    end
  end
endmodule : frd_drive_model

// ---- dv/tb_top.sv ----
// Purpose: self-checking bench for the sector read command block
// Assumes: ms tick shortened to four clocks
// Notes: host side driven here, drive side by frd_drive_model
`timescale 1ns/1ns
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_wr = 1'b0, res_rd = 1'b0, xfer_ready = 1'b1, terminal_count = 1'b0;
  logic implied_seek_en = 1'b0, seek_done = 1'b0, seek_fail = 1'b0;
  logic [7:0] cmd_data = 8'h00, seek_fail_cyl = 8'h00;
  logic [7:0] settle_ms = 8'h01, unload_ms = 8'h02;
  logic cmd_ready, res_valid, xfer_valid, seek_req, head_load, drive_busy;
  logic overwrite_enable, gap_length_select, write_gate_timing, lock_state;
  logic [7:0] res_data, xfer_data, seek_cyl, dump_sc_eot, id_sec, disk_byte;
  logic [3:0] perp_drive_bits;
  logic index_pulse_in_b, id_valid, mark_valid, mark_deleted;
  logic disk_byte_valid, data_crc_done, data_crc_ok;
  logic [7:0] last_b;
  logic [7:0] res [7];
  int errors = 0, checks_done = 0, nbytes = 0, cyc = 0;
  frd_read_cmd #(.MS_CYCLES(4)) uut (
    .clk_sys, .rst_b, .cmd_wr, .cmd_data, .cmd_ready, .res_rd, .res_data,
    .res_valid, .xfer_data, .xfer_valid, .xfer_ready, .terminal_count,
    .implied_seek_en, .settle_ms, .unload_ms, .seek_req, .seek_cyl, .seek_done,
    .seek_fail, .seek_fail_cyl, .index_pulse_in_b, .id_valid, .id_cyl(8'h00),
    .id_head(8'h00), .id_sec, .id_size(8'h00), .id_crc_ok(1'b1), .mark_valid,
    .mark_deleted, .disk_byte_valid, .disk_byte, .data_crc_done, .data_crc_ok,
    .head_load, .drive_busy, .overwrite_enable, .perp_drive_bits,
    .gap_length_select, .write_gate_timing, .lock_state, .dump_sc_eot
  );
  frd_drive_model drv (
    .clk_sys, .spin(drive_busy), .index_pulse_in_b, .id_valid, .id_sec,
    .mark_valid, .mark_deleted, .disk_byte_valid, .disk_byte, .data_crc_done,
    .data_crc_ok
  );
  always #50 clk_sys = ~clk_sys;
  // host sink for sector bytes, plus the hang limit
  always @(posedge clk_sys) begin
    cyc++;
    if (xfer_valid === 1'b1 && xfer_ready) begin
      nbytes++;
      last_b = xfer_data;
    end
    if (cyc == 40000) begin
      errors++;
      end_sim();
    end
  end
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      for (int k = 0; k < 3000 && cmd_ready !== 1'b1; k++) tick();
      cmd_data = b[i];
      cmd_wr = 1'b1;
      tick();
    end
    cmd_wr = 1'b0;
  endtask : send
  task automatic get(input int n);
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < 3000 && res_valid !== 1'b1; k++) tick();
      res[i] = res_data;
      res_rd = 1'b1;
      tick();
      res_rd = 1'b0;
      tick();
    end
  endtask : get
  // nine-byte data command, seven result bytes and sector byte count
  task automatic dcmd(input string nm, input logic [7:0] op, r, end_of_track_sector, data_length_byte,
      input int nb, input logic [7:0] s0, s1, s2);
    nbytes = 0;
    send('{op, 8'h00, 8'h00, 8'h00, r, 8'h00, end_of_track_sector, 8'h1b, data_length_byte});
    get(7);
    chk({nm, " count"}, 8'(nbytes), 8'(nb));
    if (nb > 0) chk({nm, " last"}, last_b, data_length_byte - 8'h01);
    chk({nm, " st0"}, res[0], s0);
    chk({nm, " st1"}, res[1], s1);
    chk({nm, " st2"}, res[2], s2);
  endtask : dcmd
  task automatic t_misc;
    send('{8'h1f});
    get(1);
    chk("bad st0", res[0], 8'h80);
    chk("bad one byte", {7'h00, res_valid}, 8'h00);
    send('{8'h94});
    get(1);
    chk("lock res", res[0], 8'h10);
    chk("lock out", {7'h00, lock_state}, 8'h01);
    send('{8'h12, 8'ha5});
    tick();
    chk("perp", {overwrite_enable, 1'b0, perp_drive_bits, gap_length_select,
        write_gate_timing}, 8'ha5);
    send('{8'h0d, 8'h00, 8'h02, 8'h09, 8'h1b, 8'he5});
    get(7);
    chk("dump sc", dump_sc_eot, 8'h09);
    $display("test misc done");
  endtask : t_misc
  task automatic t_read;
    dcmd("multi", 8'h06, 8'h01, 8'h02, 8'h03, 6, 8'h00, 8'h00, 8'h00);
    chk("head loaded", {7'h00, head_load}, 8'h01);
    chk("dump eot", dump_sc_eot, 8'h02);
    repeat (60) tick();
    chk("head unloaded", {7'h00, head_load}, 8'h00);
    send('{8'h4a, 8'h00});
    get(7);
    chk("rdid sec", res[5], 8'h01);
    chk("rdid st0", res[0], 8'h00);
    $display("test read done");
  endtask : t_read
  task automatic t_marks;
    drv.del_mask = 2'h1;
    dcmd("keep", 8'h06, 8'h01, 8'h02, 8'h03, 3, 8'h00, 8'h00, 8'h40);
    dcmd("skip", 8'h26, 8'h01, 8'h02, 8'h03, 3, 8'h00, 8'h00, 8'h40);
    drv.del_mask = 2'h0;
    dcmd("mt", 8'h86, 8'h01, 8'h02, 8'h03, 6, 8'h40, 8'h04, 8'h00);
    chk("mt head", res[4], 8'h01);
    $display("test marks done");
  endtask : t_marks
  task automatic t_errs;
    drv.crc_bad = 1'b1;
    dcmd("crc", 8'h06, 8'h01, 8'h01, 8'h03, 3, 8'h40, 8'h20, 8'h00);
    drv.crc_bad = 1'b0;
    dcmd("none", 8'h06, 8'h05, 8'h05, 8'h03, 0, 8'h40, 8'h04, 8'h00);
    $display("test errors done");
  endtask : t_errs
  task automatic t_seek;
    implied_seek_en = 1'b1;
    for (int k = 0; k < 2; k++) begin
      nbytes = 0;
      send('{8'h06, 8'h00, 8'(k ? 0 : 7), 8'h00, 8'h01, 8'h00, 8'h01, 8'h1b, 8'h03});
      for (int w = 0; w < 100 && seek_req !== 1'b1; w++) tick();
      chk("seek cyl", seek_cyl, 8'(k ? 0 : 7));
      chk("seek busy", {7'h00, drive_busy}, 8'h01);
      seek_fail_cyl = 8'h33;
      {seek_fail, seek_done} = k ? 2'b01 : 2'b10;
      tick();
      {seek_fail, seek_done} = 2'b00;
      seek_fail_cyl = 8'hcc;
      get(7);
      chk("seek st0", res[0], k ? 8'h00 : 8'h50);
      if (k == 0) chk("fail cyl", res[3], 8'h33);
      if (k == 1) chk("seek count", 8'(nbytes), 8'h03);
    end
    implied_seek_en = 1'b0;
    $display("test seek done");
  endtask : t_seek
  task automatic t_ovr;
    xfer_ready = 1'b0;
    nbytes = 0;
    send('{8'h06, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h1b, 8'hff});
    for (int k = 0; k < 3000 && res_valid !== 1'b1; k++) tick();
    chk("full held", {7'h00, xfer_valid}, 8'h01);
    xfer_ready = 1'b1;
    repeat (4) tick();
    chk("ovr count", 8'(nbytes), 8'h02);
    chk("ovr last", last_b, 8'h01);
    get(7);
    nbytes = 0;
    send('{8'h06, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h02, 8'h1b, 8'hff});
    for (int k = 0; k < 3000 && nbytes == 0; k++) tick();
    terminal_count = 1'b1;
    for (int k = 0; k < 3000 && res_valid !== 1'b1; k++) tick();
    terminal_count = 1'b0;
    get(7);
    chk("tc st0", res[0], 8'h00);
    chk("tc sec", res[5], 8'h02);
    $display("test overrun done");
  endtask : t_ovr
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    t_misc();
    t_read();
    t_marks();
    t_errs();
    t_seek();
    t_ovr();
    end_sim();
  end
endmodule : tb_top
